//--- adc_analog_model.sv
`timescale 1ns/100ps
module adc_analog_model #(
    parameter [9:0] LEVEL = 10'h2A5
) (
    input  wire [9:0] sar_trial,
    output wire       comparator_out,
    output reg        rc_clock_tick
);
    // held input stays at or above the trial word: keep the bit
    assign comparator_out = (sar_trial <= LEVEL);
    // the rc oscillator runs free, unrelated in phase to clk_sys
    initial begin
        rc_clock_tick = 1'b0;
        forever #37 rc_clock_tick = ~rc_clock_tick;
    end
endmodule

//--- adc_conversion_control.v
`timescale 1ns/100ps
`include "adc_ctrl_consts.vh"
module adc_conversion_control (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [4:0]  trigger_events,
    input  wire        cpu_sleep,
    input  wire        conversion_irq_enable,
    input  wire        comparator_out,
    input  wire        rc_clock_tick,
    output reg         conversion_irq_flag,
    output reg         wake_request,
    output reg         converter_powered,
    output reg         sample_hold,
    output reg  [9:0]  sar_trial,
    output reg  [4:0]  channel_select,
    output reg  [1:0]  pos_reference_select
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_DELAY = 2'h1;
    localparam ST_CONV  = 2'h2;

    reg  [7:0] control_q;
    reg  [7:0] config_q;
    reg  [7:0] res_high_q;
    reg  [7:0] res_low_q;
    reg  [2:0] trig_sel_q;
    reg  [1:0] state_q;
    reg  [7:0] delay_q;
    reg  [4:0] half_q;
    reg  [6:0] div_q;
    reg  [9:0] sar_q;
    reg  [3:0] bitpos_q;
    reg        sleep_off_q;
    reg  [4:0] trig_prev_q;
    reg  [2:0] rc_sync_q;
    reg        rc_level_q;
    reg        rc_prev_q;
    reg  [2:0] slp_sync_q;
    reg        slp_level_q;
    reg        aw_hold_q;
    reg        w_hold_q;
    reg  [4:0] aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0] w_strb_q;

    wire       rc_sel   = (config_q[`CFG_CLK_LO+1:`CFG_CLK_LO] == `CLK_RC_LOW2);
    wire [2:0] clk_code = config_q[`CFG_CLK_HI:`CFG_CLK_LO];
    reg  [6:0] div_top;
    always @* begin
        case (clk_code)
            `CLK_DIV2:  div_top = 7'h00;
            `CLK_DIV4:  div_top = 7'h01;
            `CLK_DIV8:  div_top = 7'h03;
            `CLK_DIV16: div_top = 7'h07;
            `CLK_DIV32: div_top = 7'h0F;
            `CLK_DIV64: div_top = 7'h1F;
            default:    div_top = 7'h00;
        endcase
    end

    // half-period tick of the conversion clock; the rc tick passes the pin synchroniser
    wire sys_half = (div_q == div_top);
    wire rc_edge  = rc_level_q != rc_prev_q;
    wire half_tick = rc_sel ? rc_edge : sys_half;

    // trigger edges: a held level only counts once
    wire [4:0] trig_rise = trigger_events & ~trig_prev_q;
    wire       trig_hit  = (trig_sel_q <= `TRIG_TMR2) && trig_rise[trig_sel_q];

    wire wr_go   = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire wr_ctl  = wr_go && (aw_addr_q == {1'b0, `ADDR_CONTROL}) && w_strb_q[0];
    wire [7:0] ctl_wval = w_data_q[7:0] & `CTL_MASK;
    wire enabled = control_q[`CTL_ENABLE];
    wire sw_stop = wr_ctl && !ctl_wval[`CTL_START] && (state_q != ST_IDLE);
    wire sw_start = wr_ctl && ctl_wval[`CTL_START];
    wire start_req = (sw_start || trig_hit) && enabled && (state_q == ST_IDLE);
    // sleep stops a non-rc conversion; rc keeps going through sleep
    wire sleep_abort = slp_level_q && !rc_sel && (state_q != ST_IDLE);
    wire conv_done = (state_q == ST_CONV) && half_tick && (half_q == `CONV_HALF_TICKS - 5'h01);
    wire all_done  = (half_q >= `DECIDE_END);
    // last converted bit sits just above the pending trial bit; nothing converted fills zero
    wire last_bit  = (bitpos_q == 4'h9) ? 1'b0 : sar_q[bitpos_q + 4'h1];
    wire [9:0] fill_mask = all_done ? 10'h000 : (10'h3FF >> (4'h9 - bitpos_q));
    wire [9:0] partial = (sar_q & ~fill_mask) | ({10{last_bit}} & fill_mask);
    wire [9:0] load_val = conv_done ? sar_q : partial;
    wire       do_load  = conv_done || sw_stop;

    always @(posedge clk_sys) begin
        if (rst) begin
            rc_sync_q   <= 3'h0;
            rc_level_q  <= 1'b0;
            rc_prev_q   <= 1'b0;
            slp_sync_q  <= 3'h0;
            slp_level_q <= 1'b0;
            trig_prev_q <= 5'h00;
        end else begin
            rc_sync_q   <= {rc_sync_q[1:0], rc_clock_tick};
            slp_sync_q  <= {slp_sync_q[1:0], cpu_sleep};
            if (rc_sync_q[1] == rc_sync_q[2]) rc_level_q <= rc_sync_q[2];
            if (slp_sync_q[1] == slp_sync_q[2]) slp_level_q <= slp_sync_q[2];
            rc_prev_q   <= rc_level_q;
            trig_prev_q <= trigger_events;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
            delay_q <= 8'h00;
            half_q  <= 5'h00;
            div_q   <= 7'h00;
            sar_q   <= 10'h000;
            bitpos_q <= 4'h9;
            res_high_q <= 8'h00;
            res_low_q  <= 8'h00;
            conversion_irq_flag <= 1'b0;
            wake_request <= 1'b0;
            sleep_off_q  <= 1'b0;
        end else begin
            div_q <= (sys_half || state_q == ST_IDLE) ? 7'h00 : div_q + 7'h01;
            if (conversion_irq_flag && !conversion_irq_enable && !slp_level_q)
                conversion_irq_flag <= 1'b0;
            if (!slp_level_q) begin
                wake_request <= 1'b0;
                sleep_off_q  <= 1'b0;
            end
            if (sleep_abort) begin
                state_q     <= ST_IDLE;
                sleep_off_q <= 1'b1;
            end else if (!enabled) begin
                state_q <= ST_IDLE;
            end else if (do_load) begin
                state_q <= ST_IDLE;
                if (config_q[`CFG_JUSTIFY]) begin
                    res_high_q <= {6'h00, load_val[9:8]};
                    res_low_q  <= load_val[7:0];
                end else begin
                    res_high_q <= load_val[9:2];
                    res_low_q  <= {load_val[1:0], 6'h00};
                end
                if (conv_done) begin
                    conversion_irq_flag <= 1'b1;
                    if (slp_level_q && conversion_irq_enable) wake_request <= 1'b1;
                    if (slp_level_q && !conversion_irq_enable) sleep_off_q <= 1'b1;
                end
            end else if (start_req) begin
                state_q <= rc_sel ? ST_DELAY : ST_CONV;
                delay_q <= 8'h00;
                half_q  <= 5'h00;
                sar_q   <= 10'h200;
                bitpos_q <= 4'h9;
            end else begin
                case (state_q)
                    ST_DELAY: begin
                        delay_q <= delay_q + 8'h01;
                        if (delay_q == `INSTR_CYCLES - 8'h01) state_q <= ST_CONV;
                    end
                    ST_CONV: begin
                        // odd half ticks resolve one bit each, msb first
                        if (half_tick) begin
                            half_q <= half_q + 5'h01;
                            if (half_q[0] && half_q < `DECIDE_END) begin
                                // comparator follows sar_trial within a clock; a synchroniser
                                // would outlast the half period of the fastest divider
                                sar_q[bitpos_q] <= comparator_out;
                                if (bitpos_q != 4'h0) begin
                                    sar_q[bitpos_q - 4'h1] <= 1'b1;
                                    bitpos_q <= bitpos_q - 4'h1;
                                end
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    wire busy = (state_q != ST_IDLE);

    // axi4-lite write path: address and data latched independently
    always @(posedge clk_sys) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            control_q  <= 8'h00;
            config_q   <= 8'h00;
            trig_sel_q <= `TRIG_OFF;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[4:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
            // hardware clears start on finish or abort; a same-cycle trigger still wins
            if (!busy && !start_req) control_q[`CTL_START] <= 1'b0;
            if (start_req) control_q[`CTL_START] <= 1'b1;
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                if (w_strb_q[0]) begin
                    case (aw_addr_q)
                        {1'b0, `ADDR_CONTROL}: begin
                            control_q[`CTL_CHAN_HI:`CTL_ENABLE] <=
                                {ctl_wval[`CTL_CHAN_HI:`CTL_CHAN_LO],
                                 (ctl_wval[`CTL_START] && ctl_wval[`CTL_ENABLE]) || start_req,
                                 ctl_wval[`CTL_ENABLE]};
                        end
                        {1'b0, `ADDR_CONFIG}: config_q <= w_data_q[7:0] & `CFG_MASK;
                        `ADDR_TRIG_CFG: trig_sel_q <= w_data_q[2:0];
                        {1'b0, `ADDR_RES_HIGH}, {1'b0, `ADDR_RES_LOW},
                        `ADDR_SLEEP_STAT: ;
                        default: s_axi_bresp <= `RESP_SLVERR;
                    endcase
                end
            end
        end
    end

    // axi4-lite read path
    always @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr[4:0])
                    {1'b0, `ADDR_CONTROL}:  s_axi_rdata <= {24'h0, control_q};
                    {1'b0, `ADDR_CONFIG}:   s_axi_rdata <= {24'h0, config_q};
                    {1'b0, `ADDR_RES_HIGH}: s_axi_rdata <= {24'h0, res_high_q};
                    {1'b0, `ADDR_RES_LOW}:  s_axi_rdata <= {24'h0, res_low_q};
                    `ADDR_TRIG_CFG:         s_axi_rdata <= {29'h0, trig_sel_q};
                    `ADDR_SLEEP_STAT:       s_axi_rdata <= {30'h0, busy, sleep_off_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            converter_powered    <= 1'b0;
            sample_hold          <= 1'b0;
            sar_trial            <= 10'h000;
            channel_select       <= 5'h00;
            pos_reference_select <= 2'h0;
        end else begin
            converter_powered    <= enabled && !sleep_off_q && !sleep_abort;
            sample_hold          <= (state_q == ST_CONV);
            sar_trial            <= sar_q;
            channel_select       <= enabled ? control_q[`CTL_CHAN_HI:`CTL_CHAN_LO] : `CHAN_NONE;
            pos_reference_select <= config_q[`CFG_REF_HI:`CFG_REF_LO];
        end
    end
endmodule

//--- adc_conversion_control_tb_top.sv
`timescale 1ns/100ps
`include "adc_ctrl_consts.vh"
module adc_conversion_control_tb_top;
    localparam [9:0] LEVEL = 10'h2A5;
    // stopped after three decisions: lower bits copy the last decided bit
    localparam [9:0] PART = {LEVEL[9:7], {7{LEVEL[7]}}};
    reg         clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, sleep, irq_en;
    reg  [31:0] awaddr, wdata, araddr, d;
    reg  [4:0]  trig;
    reg  [1:0]  r;
    wire        awready, wready, bvalid, arready, rvalid, cmp, rc, flag, wake, pwr, sh;
    wire [1:0]  bresp, rresp, pref;
    wire [31:0] rdata;
    wire [9:0]  trial;
    wire [4:0]  chan;
    integer     mismatches, n_compared, cycles, sh_cnt, i, h;
    reg  [4:0]  codes [0:7];
    integer     half [0:7];
    adc_conversion_control DUT (.clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trigger_events(trig),
        .cpu_sleep(sleep), .conversion_irq_enable(irq_en), .comparator_out(cmp),
        .rc_clock_tick(rc), .conversion_irq_flag(flag), .wake_request(wake),
        .converter_powered(pwr), .sample_hold(sh), .sar_trial(trial),
        .channel_select(chan), .pos_reference_select(pref));
    adc_analog_model #(.LEVEL(LEVEL)) u_model (.sar_trial(trial), .comparator_out(cmp),
        .rc_clock_tick(rc));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        sh_cnt = sh ? sh_cnt + 1 : sh_cnt;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            results;
        end
    end
    task results;
        begin
            if (mismatches == 0 && n_compared > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input [80:0] name, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wr(input [31:0] a, input [31:0] v);
        begin
            @(posedge clk_sys);
            awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
            do begin
                @(posedge clk_sys);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1);
            bready <= 1'b0;
        end
    endtask
    task rd(input [31:0] a);
        begin
            @(posedge clk_sys);
            araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
            do begin
                @(posedge clk_sys);
                if (arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1);
            d = rdata; r = rresp; rready <= 1'b0;
        end
    endtask
    task start(input [31:0] cfg);
        begin
            wr(`ADDR_CONFIG, cfg);
            wr(`ADDR_CONTROL, 32'h01);
            repeat (10) @(posedge clk_sys);
            sh_cnt = 0;
            wr(`ADDR_CONTROL, 32'h03);
        end
    endtask
    task conv_wait;
        do rd(`ADDR_CONTROL); while (d[1] !== 1'b0);
    endtask
    task pulse(input integer k);
        begin
            @(posedge clk_sys) trig <= 5'h01 << k;
            @(posedge clk_sys) trig <= 5'h00;
        end
    endtask
    initial begin
        {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = 0;
        {trig, sleep, mismatches, n_compared, cycles, sh_cnt} = 0;
        irq_en = 1'b1;
        rst = 1'b1;
        codes = '{5'h00, 5'h04, 5'h08, 5'h13, 5'h1A, 5'h1B, 5'h1D, 5'h1F};
        half = '{1, 4, 16, 0, 2, 8, 32, 0};
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`ADDR_CONTROL); chk("control", d, 32'h00);
        rd(`ADDR_CONFIG); chk("config", d, 32'h00);
        wr(`ADDR_CONTROL, 32'hFD);
        rd(`ADDR_CONTROL); chk("control", d, 32'h7D);
        wr(`ADDR_CONFIG, 32'hFF);
        rd(`ADDR_CONFIG); chk("config", d, 32'hF3);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADDR_CONFIG, 32'h80 | i);
            @(posedge clk_sys);
            chk("ref", {30'h0, pref}, i & 3);
        end
        for (i = 0; i < 8; i = i + 1) begin
            wr(`ADDR_CONTROL, {25'h0, codes[i], 2'h1});
            @(posedge clk_sys);
            chk("chan", {27'h0, chan}, {27'h0, codes[i]});
        end
        wr(`ADDR_CONTROL, 32'h00);
        @(posedge clk_sys);
        chk("chan off", {27'h0, chan}, 32'h1E);
        start(32'h80);
        conv_wait;
        chk("flag", {31'h0, flag}, 32'h1);
        rd(`ADDR_RES_HIGH); chk("high r", d, {30'h0, LEVEL[9:8]});
        rd(`ADDR_RES_LOW); chk("low r", d, {24'h0, LEVEL[7:0]});
        for (i = 0; i < 8; i = i + 1) begin
            start({25'h0, i[2:0], 4'h0});
            repeat (3) @(posedge clk_sys);
            chk("rc delay", sh, (i % 4) != 3);
            conv_wait;
            h = 23 * half[i];
            if (h > 0) chk("length", sh_cnt >= h && sh_cnt <= h + 8, 32'h1);
            rd(`ADDR_RES_HIGH); chk("high l", d, {24'h0, LEVEL[9:2]});
            rd(`ADDR_RES_LOW); chk("low l", d, {24'h0, LEVEL[1:0], 6'h00});
        end
        wr(`ADDR_CONFIG, 32'h80);
        for (i = 0; i < 5; i = i + 1) begin
            wr(`ADDR_TRIG_CFG, i);
            pulse((i + 1) % 5);
            rd(`ADDR_CONTROL); chk("other trig", d[1], 32'h0);
            pulse(i);
            rd(`ADDR_CONTROL); chk("trig", d[1], 32'h1);
            conv_wait;
        end
        wr(`ADDR_TRIG_CFG, `TRIG_OFF);
        rd(32'h18); chk("unmapped", r, `RESP_SLVERR);
        start(32'hE0);
        repeat (195) @(posedge clk_sys);
        wr(`ADDR_CONTROL, 32'h01);
        rd(`ADDR_RES_HIGH); chk("part high", d, {30'h0, PART[9:8]});
        rd(`ADDR_RES_LOW); chk("part low", d, {24'h0, PART[7:0]});
        start(32'hE0);
        repeat (20) @(posedge clk_sys);
        sleep <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk("abort pwr", pwr, 32'h0);
        rd(`ADDR_CONTROL); chk("abort en", d[0], 32'h1);
        sleep <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk("awake pwr", pwr, 32'h1);
        for (i = 0; i < 2; i = i + 1) begin
            irq_en <= i;
            start(32'h30);
            sleep <= 1'b1;
            while ((i ? wake : flag) !== 1'b1) @(posedge clk_sys);
            @(posedge clk_sys);
            chk("wake", wake, i);
            chk("sleep pwr", pwr, i);
            rd(`ADDR_CONTROL); chk("sleep en", d[1:0], 32'h1);
            sleep <= 1'b0;
            repeat (10) @(posedge clk_sys);
        end
        results;
    end
endmodule

//--- adc_ctrl_assertions.sv
`timescale 1ns/100ps
module adc_ctrl_assertions (
    input wire        clk_sys,
    input wire        rst,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        cpu_sleep,
    input wire        conversion_irq_enable,
    input wire        conversion_irq_flag,
    input wire        wake_request,
    input wire        converter_powered,
    input wire        sample_hold
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before bready");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed early");
    a_wake_cause: assert property ($rose(wake_request) |->
        cpu_sleep && conversion_irq_enable) else $error("wake without sleep and enable");
    a_wake_flag: assert property (wake_request |-> conversion_irq_flag)
        else $error("wake without completion flag");
    a_wake_drop: assert property ($fell(cpu_sleep) |-> ##[1:6] !wake_request)
        else $error("wake stuck after sleep ended");
    a_hold_unpowered: assert property (sample_hold && !converter_powered |=>
        !sample_hold) else $error("converting while powered down");
    a_flag_at_end: assert property ($rose(conversion_irq_flag) |->
        sample_hold || $past(sample_hold)) else $error("flag set outside conversion");
    a_conv_min: assert property ($rose(sample_hold) |=> sample_hold[*8])
        else $error("conversion too short");
endmodule
bind adc_conversion_control adc_ctrl_assertions u_chk (.clk_sys, .rst, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_sleep,
    .conversion_irq_enable, .conversion_irq_flag, .wake_request, .converter_powered,
    .sample_hold);

//--- adc_ctrl_consts.vh
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
// register byte addresses
`define ADDR_CONTROL     4'h0
`define ADDR_CONFIG      4'h4
`define ADDR_RES_HIGH    4'h8
`define ADDR_RES_LOW     4'hC
`define ADDR_TRIG_CFG    5'h10
`define ADDR_SLEEP_STAT  5'h14
// control fields
`define CTL_ENABLE       0
`define CTL_START        1
`define CTL_CHAN_HI      6
`define CTL_CHAN_LO      2
`define CTL_MASK         8'h7F
// config fields
`define CFG_JUSTIFY      7
`define CFG_CLK_HI       6
`define CFG_CLK_LO       4
`define CFG_REF_HI       1
`define CFG_REF_LO       0
`define CFG_MASK         8'hF3
// clock select codes; x11 means the rc oscillator
`define CLK_DIV2         3'h0
`define CLK_DIV4         3'h4
`define CLK_DIV8         3'h1
`define CLK_DIV16        3'h5
`define CLK_DIV32        3'h2
`define CLK_DIV64        3'h6
`define CLK_RC_LOW2      2'h3
// trigger source codes
`define TRIG_CCP_ONE     3'h0
`define TRIG_CCP_TWO     3'h1
`define TRIG_TMR0        3'h2
`define TRIG_TMR1        3'h3
`define TRIG_TMR2        3'h4
`define TRIG_OFF         3'h7
// conversion length in half conversion clock periods (11.5 periods)
`define CONV_HALF_TICKS  5'h17
`define HALF_TICK_BITS   5
// half tick count after which all ten bits are decided
`define DECIDE_END       5'h14
// channel code that connects nothing, driven while disabled
`define CHAN_NONE        5'h1E
// one instruction cycle of delay before an rc-clocked start, in system clocks
`define INSTR_CYCLES     8'h04
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif
